//--- logic/cca_pkg.sv
// Package for the calendar clock area: word offsets, control bit positions,
// field limits, reset values and the one-second timing figures.
// Assumes a single 125 MHz system clock and 16-bit data words.
package cca_pkg;

  // Word indices of the four calendar words in the retained area.
  localparam logic [7:0] CCA_OFS_SEC_MIN = 8'h12;
  localparam logic [7:0] CCA_OFS_HOUR_DAY = 8'h13;
  localparam logic [7:0] CCA_OFS_MON_YEAR = 8'h14;
  localparam logic [7:0] CCA_OFS_WDAY_CTRL = 8'h15;

  // Control bit positions inside the weekday/control word.
  localparam int CCA_BIT_ROUND = 13;
  localparam int CCA_BIT_STOP = 14;
  localparam int CCA_BIT_SET = 15;

  // Number of BCD fields and their order in the carry chain.
  localparam int CCA_NFIELD = 7;
  localparam int CCA_F_SEC = 0;
  localparam int CCA_F_MIN = 1;
  localparam int CCA_F_HOUR = 2;
  localparam int CCA_F_DAY = 3;
  localparam int CCA_F_MON = 4;
  localparam int CCA_F_YEAR = 5;
  localparam int CCA_F_WDAY = 6;

  // Field limits in BCD; the day limit is replaced by the month length.
  localparam logic [7:0] CCA_SEC_MAX = 8'h59;
  localparam logic [7:0] CCA_MIN_MAX = 8'h59;
  localparam logic [7:0] CCA_HOUR_MAX = 8'h23;
  localparam logic [7:0] CCA_MON_MAX = 8'h12;
  localparam logic [7:0] CCA_YEAR_MAX = 8'h99;
  localparam logic [7:0] CCA_WDAY_MAX = 8'h06;
  localparam logic [7:0] CCA_ZERO = 8'h00;
  localparam logic [7:0] CCA_ONE = 8'h01;
  localparam logic [7:0] CCA_ROUND_UP = 8'h30;

  // Values after reset: 00:00:00 on day 01 of month 01, year 00, Saturday.
  localparam logic [7:0] CCA_RST_SEC = 8'h00;
  localparam logic [7:0] CCA_RST_MIN = 8'h00;
  localparam logic [7:0] CCA_RST_HOUR = 8'h00;
  localparam logic [7:0] CCA_RST_DAY = 8'h01;
  localparam logic [7:0] CCA_RST_MON = 8'h01;
  localparam logic [7:0] CCA_RST_YEAR = 8'h00;
  localparam logic [7:0] CCA_RST_WDAY = 8'h06;
  localparam logic [15:0] CCA_RST_WORD = 16'h0000;

  // One second in nanoseconds, the clock period and the derived cycle count.
  localparam longint CCA_SECOND_NS = 1000000000;
  localparam longint CCA_CLK_PERIOD_NS = 8;
  localparam int CCA_SECOND_CYCLES = int'(CCA_SECOND_NS / CCA_CLK_PERIOD_NS);

endpackage

//--- logic/cca_bcd_step.sv
// One two-digit BCD counter step with a programmable range.
// Assumes the current value is valid BCD inside [lo, hi].
`timescale 1ns/1ps
module cca_bcd_step (
  input wire logic [7:0] val,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  output logic [7:0] nxt,
  output logic wrap
);

  // At or past the top the field restarts at its floor and signals a carry;
  // using >= also pulls an out-of-range value back into range.
  always_comb begin
    wrap = (val >= hi);
    if (wrap) begin
      nxt = lo;
    end else if (val[3:0] == 4'h9) begin
      // Units digit rolls over into the tens digit.
      nxt = {val[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {val[7:4], val[3:0] + 4'h1};
    end
  end

endmodule

//--- logic/cca_calendar_clock.sv
// Calendar clock area: seven BCD fields in four 16-bit retained words,
// with stop, round-off and set control bits in the last word.
// Assumes word access from the program side on clk_sys and a one-cycle
// scan_tick pulse from the scan sequencer on the same clock.
//
// Behaviour
// - Running clock shows date, weekday, time in BCD.
// - Word one: seconds, minutes; word two: hours, day.
// - Day of month follows month length and leap.
// - Word three: month low, year high byte.
// - Weekday low byte of control, Sunday zero.
// - Round-off below 30: seconds zero only.
// - Round-off at 30 up: zero, minute plus.
// - Stop bit set halts counting; clear runs.
// - Set bit loads values, clears set, stop.
// - Words refresh once per scan while running.
`timescale 1ns/1ps
module cca_calendar_clock
  import cca_pkg::*;
#(
  parameter int SECOND_CYCLES = CCA_SECOND_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scan_tick,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  output logic clock_running
);

  // Last valid day of a month, with leap years every fourth year of 00..99.
  function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    unique case (mon)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // Live counting fields, one byte each in chain order.
  logic [7:0] fld_q [CCA_NFIELD];
  logic [7:0] fld_d [CCA_NFIELD];
  // Visible words, seen and written by the program.
  logic [15:0] sec_min_word_q, sec_min_word_d;
  logic [15:0] hour_day_word_q, hour_day_word_d;
  logic [15:0] mon_year_word_q, mon_year_word_d;
  logic [15:0] wday_ctrl_word_q, wday_ctrl_word_d;
  // One-second prescaler.
  logic [31:0] pre_q, pre_d;
  // Registered read data.
  logic [15:0] rd_data_q, rd_data_d;

  // Per-field step results and the carry chain enables.
  logic [7:0] lo [CCA_NFIELD];
  logic [7:0] hi [CCA_NFIELD];
  logic [7:0] step [CCA_NFIELD];
  logic wrap [CCA_NFIELD];
  logic en [CCA_NFIELD];

  logic stop_bit, set_bit, round_bit;
  logic sec_tick;
  logic round_now;
  logic round_carry;

  assign stop_bit = wday_ctrl_word_q[CCA_BIT_STOP];
  assign set_bit = wday_ctrl_word_q[CCA_BIT_SET];
  assign round_bit = wday_ctrl_word_q[CCA_BIT_ROUND];
  assign clock_running = ~stop_bit;

  // Range of each field; the day limit tracks the current month and year.
  always_comb begin
    lo[CCA_F_SEC] = CCA_ZERO;
    hi[CCA_F_SEC] = CCA_SEC_MAX;
    lo[CCA_F_MIN] = CCA_ZERO;
    hi[CCA_F_MIN] = CCA_MIN_MAX;
    lo[CCA_F_HOUR] = CCA_ZERO;
    hi[CCA_F_HOUR] = CCA_HOUR_MAX;
    lo[CCA_F_DAY] = CCA_ONE;
    hi[CCA_F_DAY] = last_day(fld_q[CCA_F_MON], fld_q[CCA_F_YEAR]);
    lo[CCA_F_MON] = CCA_ONE;
    hi[CCA_F_MON] = CCA_MON_MAX;
    lo[CCA_F_YEAR] = CCA_ZERO;
    hi[CCA_F_YEAR] = CCA_YEAR_MAX;
    lo[CCA_F_WDAY] = CCA_ZERO;
    hi[CCA_F_WDAY] = CCA_WDAY_MAX;
  end

  // One incrementer per field.
  for (genvar g = 0; g < CCA_NFIELD; g++) begin : g_step
    cca_bcd_step u_step (
      .val(fld_q[g]),
      .lo(lo[g]),
      .hi(hi[g]),
      .nxt(step[g]),
      .wrap(wrap[g])
    );
  end

  // The second tick fires only while running; rounding rides the scan so
  // that it acts at a defined point and exactly once.
  assign sec_tick = ~stop_bit && (pre_q == 32'(SECOND_CYCLES - 1));
  assign round_now = round_bit && ~set_bit && scan_tick;
  assign round_carry = round_now && (fld_q[CCA_F_SEC] >= CCA_ROUND_UP);

  // Carry chain: each field advances when the one below it wraps; the
  // weekday advances with the day. A round-off carry enters at minutes.
  always_comb begin
    en[CCA_F_SEC] = sec_tick && ~round_now;
    en[CCA_F_MIN] = (en[CCA_F_SEC] && wrap[CCA_F_SEC]) || round_carry;
    en[CCA_F_HOUR] = en[CCA_F_MIN] && wrap[CCA_F_MIN];
    en[CCA_F_DAY] = en[CCA_F_HOUR] && wrap[CCA_F_HOUR];
    en[CCA_F_MON] = en[CCA_F_DAY] && wrap[CCA_F_DAY];
    en[CCA_F_YEAR] = en[CCA_F_MON] && wrap[CCA_F_MON];
    en[CCA_F_WDAY] = en[CCA_F_DAY];
  end

  // Next values of the fields, the prescaler and the visible words.
  always_comb begin
    for (int i = 0; i < CCA_NFIELD; i++) begin
      fld_d[i] = en[i] ? step[i] : fld_q[i];
    end
    pre_d = sec_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
    if (stop_bit) begin
      // A stopped clock also holds its fraction of a second.
      pre_d = pre_q;
    end
    sec_min_word_d = sec_min_word_q;
    hour_day_word_d = hour_day_word_q;
    mon_year_word_d = mon_year_word_q;
    wday_ctrl_word_d = wday_ctrl_word_q;

    if (round_now) begin
      // Seconds go to zero either way; the minute carry is in the chain.
      fld_d[CCA_F_SEC] = CCA_ZERO;
      wday_ctrl_word_d[CCA_BIT_ROUND] = 1'b0;
      pre_d = 32'h0000_0000;
    end

    if (set_bit) begin
      // Load the written words into the counters and start from them.
      fld_d[CCA_F_SEC] = sec_min_word_q[7:0];
      fld_d[CCA_F_MIN] = sec_min_word_q[15:8];
      fld_d[CCA_F_HOUR] = hour_day_word_q[7:0];
      fld_d[CCA_F_DAY] = hour_day_word_q[15:8];
      fld_d[CCA_F_MON] = mon_year_word_q[7:0];
      fld_d[CCA_F_YEAR] = mon_year_word_q[15:8];
      fld_d[CCA_F_WDAY] = wday_ctrl_word_q[7:0];
      wday_ctrl_word_d[CCA_BIT_SET] = 1'b0;
      wday_ctrl_word_d[CCA_BIT_STOP] = 1'b0;
      pre_d = 32'h0000_0000;
    end else if (scan_tick && ~stop_bit) begin
      // Refresh the visible words once per scan while running. The
      // counters are shown as they stand before this edge.
      sec_min_word_d = {fld_q[CCA_F_MIN], fld_q[CCA_F_SEC]};
      hour_day_word_d = {fld_q[CCA_F_DAY], fld_q[CCA_F_HOUR]};
      mon_year_word_d = {fld_q[CCA_F_YEAR], fld_q[CCA_F_MON]};
      wday_ctrl_word_d[7:0] = fld_q[CCA_F_WDAY];
    end

    // A program write wins over the refresh and the self-clear in the same
    // cycle; the writer is expected to stop the clock first anyway.
    if (wr_en) begin
      unique case (wr_addr)
        CCA_OFS_SEC_MIN: sec_min_word_d = wr_data;
        CCA_OFS_HOUR_DAY: hour_day_word_d = wr_data;
        CCA_OFS_MON_YEAR: mon_year_word_d = wr_data;
        CCA_OFS_WDAY_CTRL: begin
          // Bits 8 to 12 have no function and are kept at zero; a write of
          // 16'h4000..16'h4006 stops and sets the weekday in one access.
          wday_ctrl_word_d = {wr_data[15:13], 5'h00, wr_data[7:0]};
        end
        default: begin
          // Writes outside the area are ignored.
        end
      endcase
    end

    // Registered read of the visible words; others read as zero.
    rd_data_d = rd_data_q;
    if (rd_en) begin
      unique case (rd_addr)
        CCA_OFS_SEC_MIN: rd_data_d = sec_min_word_q;
        CCA_OFS_HOUR_DAY: rd_data_d = hour_day_word_q;
        CCA_OFS_MON_YEAR: rd_data_d = mon_year_word_q;
        CCA_OFS_WDAY_CTRL: rd_data_d = wday_ctrl_word_q;
        default: rd_data_d = 16'h0000;
      endcase
    end
  end

  // All state registers; reset gives a running clock at a fixed date.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fld_q[CCA_F_SEC] <= CCA_RST_SEC;
      fld_q[CCA_F_MIN] <= CCA_RST_MIN;
      fld_q[CCA_F_HOUR] <= CCA_RST_HOUR;
      fld_q[CCA_F_DAY] <= CCA_RST_DAY;
      fld_q[CCA_F_MON] <= CCA_RST_MON;
      fld_q[CCA_F_YEAR] <= CCA_RST_YEAR;
      fld_q[CCA_F_WDAY] <= CCA_RST_WDAY;
      sec_min_word_q <= {CCA_RST_MIN, CCA_RST_SEC};
      hour_day_word_q <= {CCA_RST_DAY, CCA_RST_HOUR};
      mon_year_word_q <= {CCA_RST_YEAR, CCA_RST_MON};
      wday_ctrl_word_q <= {8'h00, CCA_RST_WDAY};
      pre_q <= 32'h0000_0000;
      rd_data_q <= CCA_RST_WORD;
    end else begin
      fld_q <= fld_d;
      sec_min_word_q <= sec_min_word_d;
      hour_day_word_q <= hour_day_word_d;
      mon_year_word_q <= mon_year_word_d;
      wday_ctrl_word_q <= wday_ctrl_word_d;
      pre_q <= pre_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

endmodule

//--- verif/cca_calendar_clock_props.sv
// Checker for the calendar clock area: control bits and word ranges.
// Assumes it is bound to cca_calendar_clock and sees only its ports.
`timescale 1ns/1ps
module cca_calendar_clock_props
  import cca_pkg::*;
#(
  parameter int SECOND_CYCLES = CCA_SECOND_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scan_tick,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic clock_running
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // A write that lands on the control word.
  logic ctl_wr;
  assign ctl_wr = wr_en && (wr_addr == CCA_OFS_WDAY_CTRL);
  a_stop_halts:
    assert property (ctl_wr && wr_data[CCA_BIT_STOP] && !wr_data[CCA_BIT_SET] |=> !clock_running)
    else $error("Clock still running after a stop write.");
  a_clear_runs:
    assert property (ctl_wr && !wr_data[CCA_BIT_STOP] && !wr_data[CCA_BIT_SET] |=> clock_running)
    else $error("Clock halted after a run write.");
  a_set_resumes:
    assert property (ctl_wr && wr_data[CCA_BIT_SET] |-> ##2 clock_running)
    else $error("Set write did not restart the clock.");
  a_rd_holds:
    assert property (!rd_en |=> $stable(rd_data))
    else $error("Read data moved without a read.");
  a_unmapped_zero:
    assert property (rd_en && (rd_addr < 8'h12 || rd_addr > 8'h15) |=> rd_data == 16'h0000)
    else $error("Unmapped read gave nonzero data.");
  a_secmin_range:
    assert property (rd_en && rd_addr == 8'h12 |=> rd_data[7:0] <= 8'h59 && rd_data[15:8] <= 8'h59)
    else $error("Seconds or minutes out of range.");
  a_hourday_range:
    assert property (rd_en && rd_addr == 8'h13 |=> rd_data[7:0] <= 8'h23
      && rd_data[15:8] inside {[8'h01:8'h31]})
    else $error("Hours or day out of range.");
  a_month_range:
    assert property (rd_en && rd_addr == 8'h14 |=> rd_data[7:0] inside {[8'h01:8'h12]})
    else $error("Month out of range.");
  a_wday_format:
    assert property (rd_en && rd_addr == 8'h15 |=> rd_data[12:8] == 5'h00 && rd_data[7:0] <= 8'h06)
    else $error("Control word weekday malformed.");
  c_set: cover property (ctl_wr && wr_data[CCA_BIT_SET]);
  c_round: cover property (ctl_wr && wr_data[CCA_BIT_ROUND]);
  c_scan_run: cover property (scan_tick && clock_running);
endmodule

bind cca_calendar_clock cca_calendar_clock_props #(.SECOND_CYCLES(SECOND_CYCLES))
  cca_calendar_clock_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .scan_tick(scan_tick), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
  .clock_running(clock_running));

//--- verif/cca_calendar_clock_tb.sv
// Self-checking bench for the calendar clock area.
// Assumes a ten-cycle second so that carries show within a few cycles.
`timescale 1ns/1ps
module cca_calendar_clock_tb
  import cca_pkg::*;
;
  logic clk_sys, rst_n, scan_tick, wr_en, rd_en, clock_running;
  logic [7:0] wr_addr, rd_addr, d, m, y, wd;
  logic [15:0] wr_data, rd_data;
  logic [23:0] n;
  int fails, comparisons, cycles;
  // Corner dates: century wrap, leap and plain February.
  logic [7:0] cm[4] = '{8'h12, 8'h02, 8'h02, 8'h02};
  logic [7:0] cy[4] = '{8'h99, 8'h00, 8'h01, 8'h24};
  cca_calendar_clock #(.SECOND_CYCLES(10)) cca_calendar_clock_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .scan_tick(scan_tick), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .clock_running(clock_running));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Inputs move one nanosecond after the edge, clear of sampling.
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A write pulse, then one idle cycle so strobes never toggle twice at once.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = v;
    cyc();
    wr_en = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_en = 1'b1;
    rd_addr = a;
    cyc();
    rd_en = 1'b0;
    check(rd_data, exp);
    // Let an edge pass so that a following read never re-raises the strobe at once.
    cyc();
  endtask
  task automatic scan();
    scan_tick = 1'b1;
    cyc();
    scan_tick = 1'b0;
  endtask
  task automatic set_time(input logic [15:0] sm, hd, my, input logic [7:0] w);
    wr(CCA_OFS_WDAY_CTRL, {8'h40, w});
    wr(8'h12, sm);
    wr(8'h13, hd);
    wr(8'h14, my);
    wr(CCA_OFS_WDAY_CTRL, {8'hc0, w});
    check({15'h0, clock_running}, 16'h0001);
    rd(CCA_OFS_WDAY_CTRL, {8'h00, w});
  endtask
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  // Month length; a year divisible by four, 00 included, is a leap year.
  function automatic logic [7:0] last(input logic [7:0] mo, yr);
    case (mo)
      8'h02: return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction
  function automatic logic [23:0] nxt(input logic [7:0] dd, mo, yr);
    if (dd != last(mo, yr)) return {yr, mo, inc(dd)};
    if (mo != 8'h12) return {yr, inc(mo), 8'h01};
    return {(yr == 8'h99) ? 8'h00 : inc(yr), 8'h01, 8'h01};
  endfunction
  initial begin
    {rst_n, scan_tick, wr_en, rd_en, wr_addr, rd_addr, wr_data} = '0;
    void'($urandom(32'h142f));
    repeat (8) cyc();
    rst_n = 1'b1;
    rd(8'h12, 16'h0000);
    rd(8'h13, 16'h0100);
    rd(8'h14, 16'h0001);
    rd(8'h15, 16'h0006);
    check({15'h0, clock_running}, 16'h0001);
    wr(8'h16, 16'hffff);
    rd(8'h16, 16'h0000);
    rd(8'h11, 16'h0000);
    $display("reset and unmapped test done");
    for (int i = 0; i < 10; i++) begin
      m = (i < 4) ? cm[i] : bcd($urandom_range(12, 1));
      y = (i < 4) ? cy[i] : bcd($urandom_range(99, 0));
      wd = (i < 4) ? 8'h06 : bcd($urandom_range(6, 0));
      d = i[0] ? 8'h28 : last(m, y);
      n = nxt(d, m, y);
      set_time(16'h5959, {d, 8'h23}, {y, m}, wd);
      repeat (11) cyc();
      scan();
      rd(8'h12, 16'h0000);
      rd(8'h13, {n[7:0], 8'h00});
      rd(8'h14, n[23:8]);
      rd(8'h15, {8'h00, (wd == 8'h06) ? 8'h00 : wd + 8'h01});
    end
    $display("carry test done");
    for (int k = 0; k < 2; k++) begin
      set_time({8'h20, k ? 8'h29 : 8'h45}, 16'h0110, 16'h0503, 8'h01);
      wr(CCA_OFS_WDAY_CTRL, 16'h2001);
      scan();
      cyc();
      scan();
      rd(8'h12, {k ? 8'h20 : 8'h21, 8'h00});
      rd(8'h15, 16'h0001);
    end
    $display("round-off test done");
    wr(CCA_OFS_WDAY_CTRL, 16'h4002);
    check({15'h0, clock_running}, 16'h0000);
    wr(8'h12, 16'h3012);
    repeat (15) cyc();
    scan();
    repeat (15) cyc();
    scan();
    rd(8'h12, 16'h3012);
    // Counters froze at the rounded 20:00 well inside a second; a refresh
    // right after resuming shows whether any second slipped in while stopped.
    wr(CCA_OFS_WDAY_CTRL, 16'h0002);
    scan();
    rd(8'h12, 16'h2000);
    $display("stop test done");
    complete_run();
  end
endmodule
